/* File: include/rci_defines.svh */
// constants of the remote command interpreter
`ifndef RCI_DEFINES_SVH
`define RCI_DEFINES_SVH
`define RCI_CLK_HZ      40000000
`define RCI_BAUD        9600
`define RCI_CLK_PER_BIT (`RCI_CLK_HZ / `RCI_BAUD)
`define RCI_SEARCH_S    60
`define RCI_SEARCH_CYC  (64'd60 * 64'd40000000)
`define RCI_LIST_MAX    700
`define RCI_PAGE_MAX    3'h4
`define RCI_CARD_PAGES  7'h32
`define RCI_COPY_PAGE   3'h4
`define RCI_LB_LEN      16
`define RCI_MSG_LEN     28
`define RCI_CH_CR       8'h0D
`define RCI_CH_EOT      8'h04
`define RCI_CH_0        8'h30
`define RCI_CH_A        8'h41
`define RCI_CH_COMMA    8'h2C
`define RCI_CH_MINUS    8'h2D
`define RCI_CH_PLUS     8'h2B
`define RCI_CH_SPACE    8'h20
`endif

/* File: include/rci_pkg.sv */
// types of the remote command interpreter
package rci_pkg;
   typedef enum logic [1:0] {RCI_OP_NONE, RCI_OP_LOAD, RCI_OP_COPY} rci_op_t;
   typedef struct packed {
      rci_op_t          op;
      logic [5:0]       page;
      logic [11:0][7:0] name;
   } rci_card_req_t;
   typedef struct packed {
      logic       fin;
      logic [5:0] page;
      logic [7:0] ch;
   } rci_card_item_t;
   typedef struct packed {
      logic signed [14:0] area;
      logic        [13:0] differential_area_comparison;
      logic        [13:0] corona;
   } rci_result_t;
endpackage

/* File: logic/rci_top.sv */
// remote ascii command interpreter with serial port
`timescale 1ns/10ps
`include "rci_defines.svh"
module rci_top
   import rci_pkg::*;
#(
   parameter int unsigned CLK_PER_BIT = `RCI_CLK_PER_BIT,
   parameter logic [31:0] SEARCH_CYC  = 32'(`RCI_SEARCH_CYC),
   parameter int unsigned LIST_MAX    = `RCI_LIST_MAX
) (
   input  wire logic           clk_i,
   input  wire logic           reset_n_i,
   input  wire logic           ce_i,
   input  wire logic           rxd_i,
   output logic                txd_o,
   input  wire logic           dtr_i,
   output logic                cts_o,
   output logic                dsr_o,
   output logic                dcd_o,
   input  wire rci_result_t    result_i,
   input  wire logic [15:0]    hv_dac_i,
   output logic [2:0]          page_o,
   output rci_card_req_t       card_req_o,
   input  wire logic           card_done_i,
   input  wire logic           card_found_i,
   input  wire rci_card_item_t card_item_i,
   input  wire logic           card_vld_i,
   output logic                card_rdy_o
);
   typedef enum {RCI_IDLE, RCI_CARD, RCI_SEND, RCI_LIST} rci_state_t;

   function automatic logic [31:0] dec4(input logic [13:0] v);
      logic [13:0] c;
      c = (v > 14'd9999) ? 14'd9999 : v;
      dec4 = {`RCI_CH_0 + 8'(c / 14'd1000), `RCI_CH_0 + 8'((c / 14'd100) % 14'd10),
              `RCI_CH_0 + 8'((c / 14'd10) % 14'd10), `RCI_CH_0 + 8'(c % 14'd10)};
   endfunction
   function automatic logic [7:0] hex1(input logic [3:0] n);
      hex1 = (n < 4'hA) ? `RCI_CH_0 + 8'(n) : `RCI_CH_A + 8'(n - 4'hA);
   endfunction
   ////////////////////////////////////////////////////////////////////
   // serial receiver, 8 data bits, 1 stop, no parity
   logic [15:0] rx_tmr_q;
   logic [3:0]  rx_bit_q;
   logic        rx_busy_q;
   logic [7:0]  rx_sh_q;
   logic        rx_vld_q;
   // host TXD arrives on rxd_i; line assumed already synchronous
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_tmr_q  <= 16'h0000;
         rx_bit_q  <= 4'h0;
         rx_busy_q <= 1'b0;
         rx_sh_q   <= 8'h00;
         rx_vld_q  <= 1'b0;
      end else if (ce_i) begin
         rx_vld_q <= 1'b0;
         if (!rx_busy_q) begin
            if (!rxd_i) begin
               rx_busy_q <= 1'b1;
               rx_tmr_q  <= 16'(CLK_PER_BIT / 2);
               rx_bit_q  <= 4'h0;
            end
         end else if (rx_tmr_q != 16'h0000) begin
            rx_tmr_q <= rx_tmr_q - 16'h0001;
         end else begin
            rx_tmr_q <= 16'(CLK_PER_BIT - 1);
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && rxd_i) begin
               rx_busy_q <= 1'b0; // glitch, not a start bit
            end else if (rx_bit_q != 4'h0 && rx_bit_q <= 4'h8) begin
               rx_sh_q <= {rxd_i, rx_sh_q[7:1]};
            end else if (rx_bit_q == 4'h9) begin
               rx_busy_q <= 1'b0;
               rx_vld_q  <= rxd_i; // framing error drops the byte
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // serial transmitter and modem status lines
   logic [9:0]  tx_sh_q;
   logic [15:0] tx_tmr_q;
   logic [3:0]  tx_bit_q;
   logic        tx_busy_q;
   logic        tx_go;
   logic [7:0]  tx_byte;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_sh_q   <= 10'h3FF;
         tx_tmr_q  <= 16'h0000;
         tx_bit_q  <= 4'h0;
         tx_busy_q <= 1'b0;
         txd_o     <= 1'b1;
         cts_o     <= 1'b0;
         dsr_o     <= 1'b0;
         dcd_o     <= 1'b0;
      end else if (ce_i) begin
         dsr_o <= 1'b1;
         dcd_o <= 1'b1;
         cts_o <= dtr_i; // only clear to send while the host is ready
         txd_o <= tx_sh_q[0];
         if (tx_go) begin
            tx_sh_q   <= {1'b1, tx_byte, 1'b0};
            tx_tmr_q  <= 16'(CLK_PER_BIT - 1);
            tx_bit_q  <= 4'h0;
            tx_busy_q <= 1'b1;
         end else if (tx_busy_q) begin
            if (tx_tmr_q != 16'h0000) begin
               tx_tmr_q <= tx_tmr_q - 16'h0001;
            end else begin
               tx_tmr_q <= 16'(CLK_PER_BIT - 1);
               tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
               tx_bit_q <= tx_bit_q + 4'h1;
               tx_busy_q <= (tx_bit_q != 4'h9);
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // command decode on the received line
   rci_state_t  st_q;
   logic [7:0]  lb_q [0:`RCI_LB_LEN-1];
   logic [4:0]  lb_len_q;
   logic        lb_ovf_q;
   logic [7:0]  msg_q [0:`RCI_MSG_LEN-1];
   logic [4:0]  msg_len_q;
   logic [4:0]  msg_idx_q;
   logic        ret_list_q;
   logic [31:0] srch_q;
   logic        have_pg_q;
   logic [5:0]  last_pg_q;
   logic [9:0]  n_ent_q;

   wire logic       eol      = rx_vld_q && (rx_sh_q == `RCI_CH_CR);
   wire logic       is_dig2  = (lb_q[3] - `RCI_CH_0) < 8'h0A;
   wire logic       is_dig3  = (lb_q[4] - `RCI_CH_0) < 8'h0A;
   wire logic [7:0] n2       = lb_q[3] - `RCI_CH_0;
   wire logic [7:0] n3       = lb_q[4] - `RCI_CH_0;
   wire logic [6:0] card_pg  = 7'(n2 * 8'd10 + n3);
   wire logic       hdr_qp   = lb_len_q >= 5'd2 && lb_q[0] == "Q" && lb_q[1] == "P";
   wire logic       qp_ok    = lb_len_q == 5'd4 && lb_q[2] == `RCI_CH_COMMA && is_dig2
                               && n2 <= 8'(`RCI_PAGE_MAX);
   wire logic       is_j     = lb_len_q == 5'd1 && lb_q[0] == "J";
   wire logic       is_p     = lb_len_q == 5'd1 && lb_q[0] == "P";
   wire logic       is_vb    = lb_len_q > 5'd3 && lb_q[0] == "V" && lb_q[1] == "B"
                               && lb_q[2] == `RCI_CH_COMMA;
   wire logic       hdr_ve   = lb_len_q >= 5'd3 && lb_q[0] == "V" && lb_q[1] == "E"
                               && lb_q[2] == `RCI_CH_COMMA;
   wire logic       ve_ok    = lb_len_q == 5'd5 && is_dig2 && is_dig3
                               && card_pg <= `RCI_CARD_PAGES;
   wire logic       is_vk    = lb_len_q == 5'd2 && lb_q[0] == "V" && lb_q[1] == "K";
   wire logic       srch_end = srch_q >= SEARCH_CYC - 32'h1;
   wire logic       take_it  = card_vld_i && card_rdy_o;
   wire logic       new_pg   = !have_pg_q || card_item_i.page != last_pg_q;
   wire logic       list_end = card_item_i.fin || n_ent_q >= 10'(LIST_MAX);
   wire logic [14:0] a_mag   = result_i.area[14] ? 15'(-result_i.area) : result_i.area;
   wire logic [31:0] a_dig   = dec4((a_mag > 15'd9999) ? 14'd9999 : a_mag[13:0]);
   wire logic [31:0] d_dig   = dec4(result_i.differential_area_comparison);
   wire logic [31:0] f_dig   = dec4(result_i.corona);
   // fixed-width result line; magnitude kept 15 bits so the most negative area still clamps
   wire logic [26:0][7:0] res_txt = {"A=", result_i.area[14] ? `RCI_CH_MINUS : `RCI_CH_PLUS,
                                     a_dig[31:8], ".", a_dig[7:0], "%,D=", d_dig[31:8], ".",
                                     d_dig[7:0], "%,F=", f_dig, ",", `RCI_CH_CR};
   wire logic [6:0]  pg_bin  = 7'(card_item_i.page);
   wire logic [7:0]  pg_hi   = `RCI_CH_0 + 8'(pg_bin / 7'd10);
   wire logic [7:0]  pg_lo   = `RCI_CH_0 + 8'(pg_bin % 7'd10);
   assign tx_go   = ce_i && st_q == RCI_SEND && !tx_busy_q;
   assign tx_byte = msg_q[msg_idx_q];
   // one reply at a time; bytes received while answering are dropped
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q       <= RCI_IDLE;
         lb_len_q   <= 5'd0;
         lb_ovf_q   <= 1'b0;
         msg_len_q  <= 5'd0;
         msg_idx_q  <= 5'd0;
         ret_list_q <= 1'b0;
         srch_q     <= 32'h0;
         have_pg_q  <= 1'b0;
         last_pg_q  <= 6'h00;
         n_ent_q    <= 10'h000;
         page_o     <= 3'h0;
         card_req_o <= '0;
         card_rdy_o <= 1'b0;
         for (int i = 0; i < `RCI_LB_LEN; i++) lb_q[i] <= 8'h00;
         for (int i = 0; i < `RCI_MSG_LEN; i++) msg_q[i] <= 8'h00;
      end else if (ce_i) begin
         unique case (st_q)
            RCI_IDLE: begin
               if (eol) begin
                  lb_len_q   <= 5'd0;
                  lb_ovf_q   <= 1'b0;
                  msg_idx_q  <= 5'd0;
                  ret_list_q <= 1'b0;
                  st_q       <= RCI_SEND;
                  msg_q[1]   <= `RCI_CH_CR;
                  msg_len_q  <= 5'd2;
                  if (lb_ovf_q) begin
                     msg_q[0] <= "?";
                  end else if (hdr_qp) begin
                     msg_q[0] <= qp_ok ? "O" : "E";
                     if (qp_ok) page_o <= n2[2:0];
                  end else if (is_j) begin
                     for (int i = 0; i < 27; i++) msg_q[i] <= res_txt[26-i];
                     msg_len_q <= 5'd27;
                  end else if (is_p) begin
                     msg_q[0]  <= hex1(hv_dac_i[15:12]);
                     msg_q[1]  <= hex1(hv_dac_i[11:8]);
                     msg_q[2]  <= hex1(hv_dac_i[7:4]);
                     msg_q[3]  <= hex1(hv_dac_i[3:0]);
                     msg_q[4]  <= `RCI_CH_CR;
                     msg_len_q <= 5'd5;
                  end else if (is_vb) begin
                     card_req_o.op <= RCI_OP_LOAD;
                     for (int i = 0; i < 12; i++) begin
                        card_req_o.name[11-i] <= (5'(i + 3) < lb_len_q) ? lb_q[i+3]
                                                                         : `RCI_CH_SPACE;
                     end
                     srch_q <= 32'h0;
                     st_q   <= RCI_CARD;
                  end else if (hdr_ve) begin
                     msg_q[0] <= "2";
                     if (ve_ok) begin
                        card_req_o.op   <= RCI_OP_COPY;
                        card_req_o.page <= card_pg[5:0];
                        st_q            <= RCI_CARD;
                     end
                  end else if (is_vk) begin
                     have_pg_q  <= 1'b0;
                     n_ent_q    <= 10'h000;
                     card_rdy_o <= 1'b1;
                     st_q       <= RCI_LIST;
                  end else begin
                     msg_q[0] <= "?";
                  end
               end else if (rx_vld_q) begin
                  if (lb_len_q < 5'(`RCI_LB_LEN)) begin
                     lb_q[lb_len_q[3:0]] <= rx_sh_q;
                     lb_len_q            <= lb_len_q + 5'd1;
                  end else begin
                     lb_ovf_q <= 1'b1;
                  end
               end
            end
            RCI_CARD: begin
               // request held until a found or copy completion, or until a load search times out
               srch_q <= srch_q + 32'h1;
               if (card_done_i && card_found_i) begin
                  card_req_o.op <= RCI_OP_NONE;
                  msg_q[0]      <= "O";
                  st_q          <= RCI_SEND;
               end else if ((card_done_i && card_req_o.op == RCI_OP_COPY)
                            || (card_req_o.op == RCI_OP_LOAD && srch_end)) begin
                  card_req_o.op <= RCI_OP_NONE;
                  msg_q[0]      <= "2";
                  st_q          <= RCI_SEND;
               end
            end
            RCI_SEND: begin
               if (!tx_busy_q) begin
                  msg_idx_q <= msg_idx_q + 5'd1;
                  if (msg_idx_q == msg_len_q - 5'd1) begin
                     st_q       <= ret_list_q ? RCI_LIST : RCI_IDLE;
                     card_rdy_o <= ret_list_q;
                  end
               end
            end
            RCI_LIST: begin
               if (take_it || n_ent_q >= 10'(LIST_MAX)) begin
                  card_rdy_o <= 1'b0;
                  msg_idx_q  <= 5'd0;
                  st_q       <= RCI_SEND;
                  ret_list_q <= !list_end;
                  if (list_end) begin
                     msg_q[0]  <= `RCI_CH_EOT;
                     msg_len_q <= 5'd1;
                  end else if (new_pg) begin
                     msg_q[0]  <= pg_hi;
                     msg_q[1]  <= pg_lo;
                     msg_q[2]  <= `RCI_CH_CR;
                     msg_q[3]  <= card_item_i.ch;
                     msg_len_q <= 5'd4;
                  end else begin
                     msg_q[0]  <= card_item_i.ch;
                     msg_len_q <= 5'd1;
                  end
                  if (!list_end) begin
                     have_pg_q <= 1'b1;
                     last_pg_q <= card_item_i.page;
                     if (card_item_i.ch == `RCI_CH_CR) n_ent_q <= n_ent_q + 10'h001;
                  end
               end
            end
         endcase
      end
   end
endmodule

/* File: sim/rci_host_model.sv */
// host computer model: serial sender and receiver at a fixed bit time
`timescale 1ns/10ps
module rci_host_model #(
   parameter int unsigned BIT = 4
) (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   logic [7:0] rx_q[$];

   ////////////////////////////////////////////////////////////////////////////
   // idle line rests high, as the link does between characters
   initial rxd_o = 1'b1;

   // one character 8N1, lsb first; our out is the device's receive line
   task automatic put_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= f[i];
         repeat (BIT) @(posedge clk_i);
      end
   endtask

   // every command closes with a carriage return
   task automatic send_line(input string s);
      foreach (s[i]) put_byte(s[i]);
      put_byte(8'h0D);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // receiver samples mid-bit; queue keeps bytes so replies are never lost
   always begin
      logic [7:0] b;
      @(negedge txd_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_i);
         b[i] = txd_i;
      end
      repeat (BIT) @(posedge clk_i);
      rx_q.push_back(b);
   end
endmodule

/* File: sim/rci_checker_assertions.sv */
// concurrent checks on the ports of the remote command interpreter
`timescale 1ns/10ps
module rci_checker
   import rci_pkg::*;
#(
   parameter int unsigned CLK_PER_BIT = 4,
   parameter logic [31:0] SEARCH_CYC  = 32'h0000_0032,
   parameter int unsigned LIST_MAX    = 700
) (
   input wire logic           clk_i,
   input wire logic           reset_n_i,
   input wire logic           ce_i,
   input wire logic           rxd_i,
   input wire logic           txd_o,
   input wire logic           dtr_i,
   input wire logic           cts_o,
   input wire logic           dsr_o,
   input wire logic           dcd_o,
   input wire rci_result_t    result_i,
   input wire logic [15:0]    hv_dac_i,
   input wire logic [2:0]     page_o,
   input wire rci_card_req_t  card_req_o,
   input wire logic           card_done_i,
   input wire logic           card_found_i,
   input wire rci_card_item_t card_item_i,
   input wire logic           card_vld_i,
   input wire logic           card_rdy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   ////////////////////////////////////////////////////////////////////////////
   // a finished card job, and a list item handed over
   sequence s_done_ok;
      ce_i && card_done_i && card_req_o.op != RCI_OP_NONE
      && (card_found_i || card_req_o.op == RCI_OP_COPY);
   endsequence
   sequence s_take;
      ce_i && card_vld_i && card_rdy_o;
   endsequence

   // cycles a load request has waited, to time the absent-name answer
   logic [31:0] load_cyc_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         load_cyc_q <= 32'h0000_0000;
      end else if (ce_i) begin
         load_cyc_q <= (card_req_o.op == RCI_OP_LOAD) ? load_cyc_q + 32'h0000_0001
                                                      : 32'h0000_0000;
      end
   end

   // link status lines and page range
   chk_dsr_dcd_same: assert property (dsr_o == dcd_o)
      else $error("dsr and dcd differ");
   chk_dsr_stays: assert property (dsr_o |=> dsr_o)
      else $error("dsr dropped");
   chk_cts_follow: assert property ($past(ce_i) && $past(reset_n_i) |-> cts_o == $past(dtr_i))
      else $error("cts not one cycle behind dtr");
   chk_start_idle: assert property ($rose(reset_n_i) |-> txd_o && !card_rdy_o)
      else $error("outputs not idle after reset");
   chk_page_range: assert property (page_o <= 3'h4)
      else $error("page out of range");

   // card job request, hold and release
   chk_copy_range: assert property (card_req_o.op == RCI_OP_COPY |-> card_req_o.page <= 6'h32)
      else $error("copy of page above limit");
   chk_copy_holds: assert property (ce_i && card_req_o.op == RCI_OP_COPY && !card_done_i
      |=> $stable(card_req_o))
      else $error("copy request moved before done");
   chk_job_release: assert property (s_done_ok |=> card_req_o.op == RCI_OP_NONE)
      else $error("request kept after done");
   chk_absent_ignored: assert property (ce_i && card_done_i && !card_found_i
      && card_req_o.op == RCI_OP_LOAD |=> card_req_o.op == RCI_OP_LOAD)
      else $error("search ended early on absent name");
   chk_item_taken: assert property (s_take |=> !card_rdy_o)
      else $error("ready stayed high after take");
   chk_ce_freeze: assert property (!ce_i |=> $stable(txd_o) && $stable(page_o)
      && $stable(card_req_o))
      else $error("state moved with enable low");
   chk_search_full: assert property (ce_i && card_req_o.op == RCI_OP_LOAD
      && !(card_done_i && card_found_i) && load_cyc_q < SEARCH_CYC - 32'h1
      |=> card_req_o.op == RCI_OP_LOAD)
      else $error("absent name answered before full search");
   chk_search_ends: assert property (ce_i && card_req_o.op == RCI_OP_LOAD
      && load_cyc_q == SEARCH_CYC - 32'h1 |=> card_req_o.op == RCI_OP_NONE)
      else $error("search not ended at its limit");
endmodule

bind rci_top rci_checker #(.CLK_PER_BIT(CLK_PER_BIT), .SEARCH_CYC(SEARCH_CYC),
   .LIST_MAX(LIST_MAX)) i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
   .rxd_i(rxd_i), .txd_o(txd_o), .dtr_i(dtr_i), .cts_o(cts_o), .dsr_o(dsr_o),
   .dcd_o(dcd_o), .result_i(result_i), .hv_dac_i(hv_dac_i), .page_o(page_o),
   .card_req_o(card_req_o), .card_done_i(card_done_i), .card_found_i(card_found_i),
   .card_item_i(card_item_i), .card_vld_i(card_vld_i), .card_rdy_o(card_rdy_o));

/* File: sim/tb_rci_top.sv */
// self-checking bench of the remote command interpreter
`timescale 1ns/10ps
module tb_rci_top;
   import rci_pkg::*;
   localparam int SPB  = 4;
   localparam int SCYC = 50;
   logic           clk_i, reset_n_i, ce_i, dtr_i, rxd, txd, cts, dsr, dcd;
   logic           card_done_i, card_found_i, card_vld_i, card_rdy;
   rci_result_t    result_i;
   logic [15:0]    hv_dac_i;
   logic [2:0]     page;
   rci_card_req_t  req;
   rci_card_item_t card_item_i;
   int             fails, n_compared, cyc;

   rci_top #(.CLK_PER_BIT(SPB), .SEARCH_CYC(32'h0000_0032), .LIST_MAX(700)) i_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .rxd_i(rxd), .txd_o(txd),
      .dtr_i(dtr_i), .cts_o(cts), .dsr_o(dsr), .dcd_o(dcd), .result_i(result_i),
      .hv_dac_i(hv_dac_i), .page_o(page), .card_req_o(req), .card_done_i(card_done_i),
      .card_found_i(card_found_i), .card_item_i(card_item_i), .card_vld_i(card_vld_i),
      .card_rdy_o(card_rdy));
   rci_host_model #(.BIT(SPB)) i_host (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));

   ////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // gap first: the device drops bytes until it starts sending the last byte of its reply
   task automatic send(input string s);
      repeat (2 * SPB) @(posedge clk_i);
      i_host.send_line(s);
   endtask

   task automatic expect_reply(input string what, input string exp);
      int w;
      for (int i = 0; i < exp.len(); i++) begin
         w = 0;
         while (i_host.rx_q.size() == 0 && w < 3000) begin
            @(posedge clk_i);
            w++;
         end
         check(what, exp[i], (i_host.rx_q.size() > 0) ? i_host.rx_q.pop_front() : 8'hFF);
      end
   endtask

   task automatic cmd(input string s, input string exp, input string what);
      send(s);
      expect_reply(what, exp);
   endtask

   task automatic wait_op(input rci_op_t op);
      int w;
      w = 0;
      while (req.op !== op && w < 2000) begin
         @(posedge clk_i);
         w++;
      end
      check("card op", op, req.op);
   endtask

   task automatic card_answer(input logic found);
      card_done_i  <= 1'b1;
      card_found_i <= found;
      @(posedge clk_i);
      card_done_i  <= 1'b0;
   endtask

   // holds the item until an edge sees ready, as the stream demands
   task automatic feed(input logic f, input logic [5:0] pg, input logic [7:0] ch);
      int w;
      w = 0;
      @(posedge clk_i); // valid is never dropped and raised in one time step
      card_item_i <= {f, pg, ch};
      card_vld_i  <= 1'b1;
      do begin
         @(posedge clk_i);
         w++;
      end while (card_rdy !== 1'b1 && w < 2000);
      card_vld_i  <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_page();
      for (int n = 0; n < 5; n++) begin
         cmd($sformatf("QP,%0d", n), "O\015", "page reply");
         check("page", n, page);
      end
      cmd("QP,7", "E\015", "bad page reply");
      check("page kept", 32'h4, page);
      ce_i  <= 1'b0;
      dtr_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i  <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("cts", 32'h0, cts);
      check("dsr dcd", 32'h3, {dsr, dcd});
      dtr_i <= 1'b1;
      $display("test page done");
   endtask

   task automatic t_result();
      result_i <= '{area: 15'h7F85, differential_area_comparison: 14'h01C8, corona: 14'h0315};
      cmd("J", "A=-012.3%,D=045.6%,F=0789,\015", "result neg");
      result_i <= '{area: 15'h0005, differential_area_comparison: 14'h270F, corona: 14'h0000};
      cmd("J", "A=+000.5%,D=999.9%,F=0000,\015", "result pos");
      hv_dac_i <= 16'hA5C3;
      cmd("P", "A5C3\015", "dac hex");
      cmd("ZZ", "?\015", "unknown");
      cmd("VB,ABCDEFGHIJKLMNOP", "?\015", "long line");
      $display("test result done");
   endtask

   task automatic t_card();
      int w;
      send("VB,MASTER1");
      wait_op(RCI_OP_LOAD);
      check("name first", 32'h4D, req.name[11]);
      check("name pad", 32'h20, req.name[0]);
      repeat (5) @(posedge clk_i);
      card_answer(1'b1);
      expect_reply("load ok", "O\015");
      send("VB,NONE");
      wait_op(RCI_OP_LOAD);
      card_answer(1'b0);
      w = 0;
      while (txd === 1'b1 && w < 2000) begin
         @(posedge clk_i);
         w++;
      end
      check("search wait", 32'h1, (w + 2 >= SCYC) && (w < SCYC + 20));
      expect_reply("load absent", "2\015");
      send("VE,50");
      wait_op(RCI_OP_COPY);
      check("copy page", 32'h32, req.page);
      card_answer(1'b1);
      expect_reply("copy ok", "O\015");
      cmd("VE,51", "2\015", "copy range");
      send("VE,07");
      wait_op(RCI_OP_COPY);
      card_answer(1'b0);
      expect_reply("copy failed", "2\015");
      $display("test card done");
   endtask

   task automatic t_list();
      send("VK");
      feed(1'b0, 6'h00, 8'h41);
      feed(1'b0, 6'h00, 8'h42);
      feed(1'b0, 6'h00, 8'h0D);
      feed(1'b0, 6'h01, 8'h43);
      feed(1'b0, 6'h01, 8'h0D);
      feed(1'b1, 6'h00, 8'h00);
      expect_reply("list", "00\015AB\01501\015C\015\004");
      send("VK");
      feed(1'b1, 6'h00, 8'h00);
      expect_reply("empty list", "\004");
      $display("test list done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // a hang is cut short well past the expected run length
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      clk_i        = 1'b0;
      reset_n_i    = 1'b0;
      ce_i         = 1'b1;
      dtr_i        = 1'b1;
      card_done_i  = 1'b0;
      card_found_i = 1'b0;
      card_vld_i   = 1'b0;
      card_item_i  = '0;
      result_i     = '0;
      hv_dac_i     = 16'h0000;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      t_page();
      t_result();
      t_card();
      t_list();
      wrap_up();
   end
endmodule
